/* ppwp_unpacker.sv */
// Panel end: unpacks 32-bit link words into 10-bit RGB primaries
// Rules for the link, at both ends
// R01: Each primary is ten-bit unsigned gray level.
// R02: Larger code means brighter primary, monotonic.
// R03: Word bits 0-7 carry red bits 2-9.
// R04: Word bits 8-15 carry green bits 2-9.
// R05: Word bits 16-23 carry blue bits 2-9.
// R06: Byte three carries blue, green, red low pairs.
// R07: Receiver ignores word bits 24 and 25.
// R08: Receiver tolerates five UI inter-lane skew. The unpacker does no deskew.
// R09: Source holds signals off until supply on.
// R10: Source drives data low while supply off.
// R11: Source never leaves signals floating when idle.
// R12: Sequence gap interval never below zero.
// R13: Primary equals high byte over low pair.
`timescale 1ns/1ns
module ppwp_unpacker
  import ppwp_pkg::*;
(
  input  wire logic                        core_clk,   // Pixel clock
  input  wire logic                        rst,        // Sync reset, high
  ppwp_link_if.panel                       link,       // Link from source
  input  wire logic                        supplyEn,   // Panel logic supply request
  output logic [ppwp_pkg::PPWP_PRIM_W-1:0] redOut,     // Red gray level
  output logic [ppwp_pkg::PPWP_PRIM_W-1:0] greenOut,   // Green gray level
  output logic [ppwp_pkg::PPWP_PRIM_W-1:0] blueOut,    // Blue gray level
  output logic                             pixValid    // Pixel strobe
);
  import ppwp_pkg::*;

  // Supply FSM states
  typedef enum logic {SUP_OFF, SUP_ON} ppwp_sup_e;

  // Supply request comes from board power logic, so it is synchronised
  logic [2:0]             supSync_reg;
  logic                   supAgreed;

  // Supply state as the panel logic sees it
  ppwp_sup_e              supState_reg;
  ppwp_sup_e              supState_next;

  logic                   supply_reg;
  logic                   supply_next;

  // Word acceptance
  logic                   takeWord;

  logic                   valid_reg;
  logic                   valid_next;

  // Byte lanes of the packed word
  logic [PPWP_HI_W-1:0]   laneByte0;
  logic [PPWP_HI_W-1:0]   laneByte1;
  logic [PPWP_HI_W-1:0]   laneByte2;
  logic [PPWP_HI_W-1:0]   laneByte3;

  // Red field pieces and held code
  logic [PPWP_HI_W-1:0]   redHiByte;
  logic [PPWP_LO_W-1:0]   redLoPair;
  logic [PPWP_PRIM_W-1:0] red_reg;
  logic [PPWP_PRIM_W-1:0] red_next;

  // Green field pieces and held code
  logic [PPWP_HI_W-1:0]   greenHiByte;
  logic [PPWP_LO_W-1:0]   greenLoPair;
  logic [PPWP_PRIM_W-1:0] green_reg;
  logic [PPWP_PRIM_W-1:0] green_next;

  // Blue field pieces and held code
  logic [PPWP_HI_W-1:0]   blueHiByte;
  logic [PPWP_LO_W-1:0]   blueLoPair;
  logic [PPWP_PRIM_W-1:0] blue_reg;
  logic [PPWP_PRIM_W-1:0] blue_next;

  // A change counts once stages two and three agree, so a glitch is dropped
  assign supAgreed = (supSync_reg[1] == supSync_reg[2]);

  // Request synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      supSync_reg <= 3'h0;
    end else begin
      supSync_reg <= {supSync_reg[1:0], supplyEn};
    end
  end

  // Panel supply state
  always_comb begin
    supState_next = supState_reg;
    case (supState_reg)
      SUP_OFF: begin
        if (supAgreed && supSync_reg[2]) begin
          supState_next = SUP_ON;
        end
      end
      SUP_ON: begin
        if (supAgreed && !supSync_reg[2]) begin
          supState_next = SUP_OFF;
        end
      end
      default: begin
        supState_next = SUP_OFF;
      end
    endcase
  end

  // Next level from the agreed request
  assign supply_next = (supState_next == SUP_ON);

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      supState_reg <= SUP_OFF;
    end else begin
      supState_reg <= supState_next;
    end
  end

  // Level kept in its own register so the link sees a clean edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      supply_reg <= 1'b0;
    end else begin
      supply_reg <= supply_next;
    end
  end

  // Lane deskew lives in the serial receiver; words arrive aligned here
  assign takeWord = link.linkValid & supply_reg; // R08

  assign valid_next = takeWord;

  // Pixel strobe, one cycle per accepted word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
    end
  end

  // Byte lanes, lowest byte first
  assign laneByte0 = link.linkWord[PPWP_RED_HI +: PPWP_HI_W];

  assign laneByte1 = link.linkWord[PPWP_GRN_HI +: PPWP_HI_W];

  assign laneByte2 = link.linkWord[PPWP_BLU_HI +: PPWP_HI_W];

  assign laneByte3 = link.linkWord[PPWP_SPARE +: PPWP_HI_W];

  // High bytes in ascending byte order: red, green, blue
  assign redHiByte   = laneByte0; // R03

  assign greenHiByte = laneByte1; // R04

  assign blueHiByte  = laneByte2; // R05

  // Low pairs share the top byte; its two lowest bits are never read
  assign redLoPair   = laneByte3[PPWP_RED_LO-PPWP_SPARE +: PPWP_LO_W]; // R06 R07

  assign greenLoPair = laneByte3[PPWP_GRN_LO-PPWP_SPARE +: PPWP_LO_W]; // R06

  assign blueLoPair  = laneByte3[PPWP_BLU_LO-PPWP_SPARE +: PPWP_LO_W]; // R06

  // High byte over low pair; unsigned code keeps brightness monotonic
  assign red_next   = {redHiByte, redLoPair};     // R13 R01 R02

  assign green_next = {greenHiByte, greenLoPair}; // R13

  assign blue_next  = {blueHiByte, blueLoPair};   // R13

  // Colours hold between words, so a slow consumer still sees the last pixel
  always_ff @(posedge core_clk) begin
    if (rst) begin
      red_reg <= PPWP_PRIM_RST;
    end else if (takeWord) begin
      red_reg <= red_next;
    end
  end

  // Green code
  always_ff @(posedge core_clk) begin
    if (rst) begin
      green_reg <= PPWP_PRIM_RST;
    end else if (takeWord) begin
      green_reg <= green_next;
    end
  end

  // Blue code
  always_ff @(posedge core_clk) begin
    if (rst) begin
      blue_reg <= PPWP_PRIM_RST;
    end else if (takeWord) begin
      blue_reg <= blue_next;
    end
  end

  // Every output comes from a register
  assign link.supplyOn = supply_reg;

  assign redOut   = red_reg;

  assign greenOut = green_reg;

  assign blueOut  = blue_reg;

  assign pixValid = valid_reg;
endmodule

/* ppwp_pkg.sv */
// Shared constants for the panel pixel word packer and unpacker
package ppwp_pkg;
  localparam int PPWP_PRIM_W    = 10;
  localparam int PPWP_WORD_W    = 32;
  localparam int PPWP_HI_W      = 8;
  localparam int PPWP_LO_W      = 2;
  localparam int PPWP_RED_HI    = 0;
  localparam int PPWP_GRN_HI    = 8;
  localparam int PPWP_BLU_HI    = 16;
  localparam int PPWP_SPARE     = 24;
  localparam int PPWP_BLU_LO    = 26;
  localparam int PPWP_GRN_LO    = 28;
  localparam int PPWP_RED_LO    = 30;
  localparam int PPWP_MAX_SKEW_UI = 5;
  localparam logic [1:0] PPWP_SPARE_VAL = 2'h0;
  localparam logic [31:0] PPWP_WORD_RST = 32'h0;
  localparam logic [9:0]  PPWP_PRIM_RST = 10'h0;
endpackage

/* ppwp_link_if.sv */
// Packed-word link between pixel source and panel receiver
`timescale 1ns/1ns
interface ppwp_link_if;
  logic [31:0] linkWord;
  logic        linkValid;
  logic        supplyOn;
  modport source (output linkWord, output linkValid, input supplyOn);
  modport panel  (input linkWord, input linkValid, output supplyOn);
endinterface

/* ppwp_packer.sv */
// Source end: packs 10-bit RGB primaries into 32-bit link words
`timescale 1ns/1ns
module ppwp_packer
  import ppwp_pkg::*;
(
  input  wire logic                        core_clk,  // Pixel clock
  input  wire logic                        rst,       // Sync reset, high
  input  wire logic [ppwp_pkg::PPWP_PRIM_W-1:0] redIn,   // Red gray level
  input  wire logic [ppwp_pkg::PPWP_PRIM_W-1:0] greenIn, // Green gray level
  input  wire logic [ppwp_pkg::PPWP_PRIM_W-1:0] blueIn,  // Blue gray level
  input  wire logic                        pixValid,  // Pixel strobe
  output logic                             supplyUp,  // Panel supply seen on
  ppwp_link_if.source                      link       // Link to panel
);
  import ppwp_pkg::*;

  logic [2:0]             supSync_reg;
  logic                   supOn_reg;
  logic [PPWP_WORD_W-1:0] word_reg;
  logic                   valid_reg;
  wire  [PPWP_WORD_W-1:0] wordNext;
  wire                    supSeen;

  // Three-stage sync; change accepted when stages two and three agree
  assign supSeen = (supSync_reg[1] == supSync_reg[2]) ? supSync_reg[2] : supOn_reg;

  assign wordNext = {redIn[1:0], greenIn[1:0], blueIn[1:0], PPWP_SPARE_VAL, // R06 R01
                     blueIn[9:2], greenIn[9:2], redIn[9:2]};               // R03 R04 R05

  always_ff @(posedge core_clk) begin
    if (rst) begin
      supSync_reg <= 3'h0;
      supOn_reg   <= 1'b0;
    end else begin
      supSync_reg <= {supSync_reg[1:0], link.supplyOn};
      supOn_reg   <= supSeen;
    end
  end

  // Lines held low, never floating, until supply seen on; no reorder
  always_ff @(posedge core_clk) begin
    if (rst || !supOn_reg) begin
      word_reg  <= PPWP_WORD_RST; // R09 R10 R11 R12
      valid_reg <= 1'b0;
    end else begin
      word_reg  <= pixValid ? wordNext : PPWP_WORD_RST; // R11
      valid_reg <= pixValid;
    end
  end

  assign link.linkWord  = word_reg;
  assign link.linkValid = valid_reg;
  assign supplyUp       = supOn_reg;
endmodule

/* ppwp_link_props.sv */
// Checks on the packed-word link between packer and unpacker
`timescale 1ns/1ns
module ppwp_link_props (
  input wire logic        core_clk,  // Pixel clock
  input wire logic        rst,       // Sync reset
  input wire logic [31:0] linkWord,  // Packed word
  input wire logic        linkValid, // Word strobe
  input wire logic        supplyOn   // Supply up
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Packer sees supply changes a few cycles late
  sequence s_off; !supplyOn [*6]; endsequence
  property p_spare; linkValid |-> linkWord[25:24] == 2'h0; endproperty
  property p_idle; !linkValid |-> linkWord == 32'h0; endproperty
  property p_offV; s_off |-> !linkValid; endproperty
  property p_offW; s_off |-> linkWord == 32'h0; endproperty
  property p_rise; $rose(supplyOn) |-> !linkValid [*2]; endproperty
  sequence s_up; $rose(supplyOn); endsequence
  sequence s_quiet; !linkValid [*3]; endsequence
  property p_gap; s_up |-> s_quiet; endproperty
  a_spare: assert property (p_spare) else $error("spare bits set");
  a_idle: assert property (p_idle) else $error("idle word not zero");
  a_offV: assert property (p_offV) else $error("word sent, supply off");
  a_offW: assert property (p_offW) else $error("data high, supply off");
  a_rise: assert property (p_rise) else $error("word before supply");
  a_gap: assert property (p_gap) else $error("word too soon after supply");
  c_b2b: cover property (linkValid ##1 linkValid);
endmodule

/* tb_top.sv */
// Bench joining packer and unpacker over the link
`timescale 1ns/1ns
module tb_top;
  import ppwp_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       supplyEn = 1'b0;
  logic       pixValid = 1'b0;
  logic [9:0] redIn = 10'h0, greenIn = 10'h0, blueIn = 10'h0;
  logic [9:0] redOut, greenOut, blueOut;
  logic       supplyUp, pixOut;
  int         miscompares = 0, checked = 0;
  ppwp_link_if link ();
  ppwp_packer u_ppwp_packer (.core_clk(core_clk), .rst(rst), .redIn(redIn), .greenIn(greenIn),
    .blueIn(blueIn), .pixValid(pixValid), .supplyUp(supplyUp), .link(link));
  ppwp_unpacker u_ppwp_unpacker (.core_clk(core_clk), .rst(rst), .link(link), .supplyEn(supplyEn),
    .redOut(redOut), .greenOut(greenOut), .blueOut(blueOut), .pixValid(pixOut));
  ppwp_link_props u_ppwp_link_props (.core_clk(core_clk), .rst(rst), .linkWord(link.linkWord),
    .linkValid(link.linkValid), .supplyOn(link.supplyOn));
  always #5 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Walking bits on red and green, a stepped code on blue, so any swapped lane shows
  function automatic logic [29:0] px(input int i);
    return {10'(10'h1 << (i % 10)), 10'(10'h200 >> (i % 10)), 10'(i * 37)};
  endfunction
  function automatic logic [31:0] pk(input logic [29:0] p);
    return {p[21:20], p[11:10], p[1:0], 2'h0, p[9:2], p[19:12], p[29:22]};
  endfunction
  task automatic complete_run();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_gate();
    @(posedge core_clk) supplyEn <= 1'b0;
    repeat (12) @(posedge core_clk);
    pixValid <= 1'b1;
    {redIn, greenIn, blueIn} <= px(3);
    @(posedge core_clk) pixValid <= 1'b0;
    repeat (2) begin
      @(posedge core_clk) #1;
      check(link.linkWord, 32'h0);
      check(32'(pixOut), 32'h0);
    end
  endtask
  task automatic t_stream();
    @(posedge core_clk) supplyEn <= 1'b1;
    for (int n = 0; n < 20 && supplyUp !== 1'b1; n++) @(posedge core_clk);
    check(32'(supplyUp), 32'h1);
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      pixValid <= (i < 10);
      {redIn, greenIn, blueIn} <= px(i);
      #1;
      if (i > 0) check(link.linkWord, (i < 11) ? pk(px(i - 1)) : 32'h0);
      if (i > 1) check({pixOut, 1'b0, redOut, greenOut, blueOut}, {1'b1, 1'b0, px(i - 2)});
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_gate();
    t_stream();
    t_gate();
    complete_run();
  end
  initial begin
    repeat (1000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end
endmodule
